// ==== rsf_rx.sv ====
/*
 rsf_rx: receive status packing, receive FIFO flush, receiver halt and
 the receive error flag, behind a simple register port.
 Assumes the MAC receive logic runs on i_mclk and gives a frame as a
 start pulse, data words and an end pulse carrying the frame facts.
*/
// Behaviour
// R1 - flush resets both receive FIFO pointers
// R2 - host halts receiver before requesting flush
// R3 - flush request bit self-clears when done
// R4 - reserved status bits 31,14,9:8,0 zero
// R5 - bit 30 marks address filter fail
// R6 - frame byte length in 29:16
// R7 - bit 15 ORs bits 11,7,6,1
// R8 - bit 13 marks broadcast frame
// R9 - bit 12 marks length field mismatch
// R10 - bit 11 runt; runts kept only if pass-bad
// R11 - bit 10 marks multicast frame
// R12 - bit 7 over 1518 bytes, no truncation
// R13 - bit 6 marks late collision
// R14 - bit 5 type over 1500, never short runts
// R15 - bit 4 receive watchdog expiry
// R16 - bit 3 receive error seen in frame
// R17 - bit 2 dribble bits, not with collision
// R18 - bit 1 bad checksum or receive error
// R19 - clearing enable halts, then one halted pulse
// R20 - host sets enable again to resume
// R21 - error flag never halts the receiver
// R22 - error on FIFO underrun or status overflow
// R23 - host soft-resets after underrun
// R24 - status pushed after frame data, one pop
module rsf_rx #(
    parameter int DAW = 6,
    parameter int SAW = 4
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // mac receive side
    input wire logic i_rx_sof,
    input wire logic i_rx_wvalid,
    input wire logic [31:0] i_rx_wdata,
    input wire logic i_rx_er,
    input wire logic i_rx_eof,
    input wire logic [13:0] i_eof_len,
    input wire logic [15:0] i_eof_typelen,
    input wire logic i_eof_filt_fail,
    input wire logic i_eof_bcast,
    input wire logic i_eof_mcast,
    input wire logic i_eof_len_err,
    input wire logic i_eof_late_col,
    input wire logic i_eof_crc_bad,
    input wire logic [2:0] i_eof_drib_bits,
    input wire logic i_mii_mode,
    // status
    output logic o_receive_enable_bit,
    output logic o_rx_halted,
    output logic o_receiver_halted_event,
    output logic o_receive_error_flag
);
    typedef enum logic [1:0] {S_HALT, S_IDLE, S_FRAME} rsf_st_e;

    typedef struct packed {
        rsf_st_e st;
        logic receive_enable_bit;
        logic passbad;
        logic flush_req;
        logic err;
        logic halt_evt;
        logic mii_err;
        logic ovf;
        logic [31:0] rdata;
    } rsf_rx_s;

    rsf_rx_s r;
    rsf_rx_s n;

    logic [31:0] d_rdata;
    logic [31:0] s_rdata;
    logic d_full;
    logic d_empty;
    logic s_full;
    logic s_empty;
    logic [DAW:0] d_used;
    logic [SAW:0] s_used;
    logic d_push;
    logic d_pop;
    logic s_pop;
    logic accept;
    logic at_eof;
    logic runt;
    logic keep;
    logic s_push;
    logic d_commit;
    logic d_drop;
    logic mii_seen;
    logic [31:0] st_word;

    assign accept = (r.st == S_IDLE) && r.receive_enable_bit && i_rx_sof; // R21
    assign at_eof = (r.st == S_FRAME) && i_rx_eof;
    assign d_push = i_rx_wvalid && ((r.st == S_FRAME) || accept);
    assign d_pop = i_rd && (i_addr == rsf_pkg::A_DATA);
    assign s_pop = i_rd && (i_addr == rsf_pkg::A_STAT);
    assign mii_seen = r.mii_err || i_rx_er; // R16
    assign runt = i_eof_len < rsf_pkg::RUNT_BYTES;
    // runts are kept only when bad frames may pass
    assign keep = !r.ovf && !(d_push && d_full) && !s_full && (!runt || r.passbad); // R10
    assign s_push = at_eof && keep; // R24
    assign d_commit = s_push; // R24
    assign d_drop = at_eof && !keep;

    always_comb begin
        st_word = '0; // R4
        st_word[rsf_pkg::ST_FILT] = i_eof_filt_fail; // R5
        st_word[rsf_pkg::ST_LEN +: 14] = i_eof_len; // R6
        st_word[rsf_pkg::ST_BCAST] = i_eof_bcast; // R8
        st_word[rsf_pkg::ST_LENERR] = i_eof_len_err; // R9
        st_word[rsf_pkg::ST_RUNT] = runt; // R10
        st_word[rsf_pkg::ST_MCAST] = i_eof_mcast; // R11
        // length is counted, never truncated
        st_word[rsf_pkg::ST_LONG] = i_eof_len > rsf_pkg::MAX_BYTES; // R12
        st_word[rsf_pkg::ST_LATE] = i_eof_late_col; // R13
        st_word[rsf_pkg::ST_TYPE] = (i_eof_typelen > rsf_pkg::TYPE_MIN)
            && (i_eof_len >= rsf_pkg::HDR_BYTES); // R14
        st_word[rsf_pkg::ST_WDOG] = i_eof_len > rsf_pkg::WDOG_BYTES; // R15
        st_word[rsf_pkg::ST_MIIERR] = mii_seen; // R16
        st_word[rsf_pkg::ST_DRIB] = !i_eof_late_col && (i_mii_mode
            ? (i_eof_drib_bits == rsf_pkg::DRIB_NIB)
            : (i_eof_drib_bits >= rsf_pkg::DRIB_10M)); // R17
        st_word[rsf_pkg::ST_CRC] = i_eof_crc_bad || mii_seen; // R18
        st_word[rsf_pkg::ST_ES] = st_word[rsf_pkg::ST_RUNT]
            | st_word[rsf_pkg::ST_LONG] | st_word[rsf_pkg::ST_LATE]
            | st_word[rsf_pkg::ST_CRC]; // R7
    end

    rsf_fifo #(.W(32), .AW(DAW)) u_data (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_flush(r.flush_req),
        .i_commit(d_commit),
        .i_drop(d_drop),
        .i_push(d_push),
        .i_wdata(i_rx_wdata),
        .i_pop(d_pop),
        .o_rdata(d_rdata),
        .o_full(d_full),
        .o_empty(d_empty),
        .o_used(d_used)
    );

    rsf_fifo #(.W(32), .AW(SAW)) u_stat (
        .i_mclk(i_mclk),
        .i_reset(i_reset),
        .i_flush(r.flush_req),
        .i_commit(s_push),
        .i_drop(1'b0),
        .i_push(s_push),
        .i_wdata(st_word),
        .i_pop(s_pop),
        .o_rdata(s_rdata),
        .o_full(s_full),
        .o_empty(s_empty),
        .o_used(s_used)
    );

    always_comb begin
        n = r;
        n.halt_evt = 1'b0;
        n.rdata = '0;
        // flush takes one cycle, then the request drops by itself
        if (r.flush_req) begin
            n.flush_req = 1'b0; // R3
        end
        case (r.st)
            S_HALT: begin
                if (r.receive_enable_bit) begin
                    n.st = S_IDLE; // R20
                end
            end
            S_IDLE: begin
                if (!r.receive_enable_bit) begin
                    n.st = S_HALT; // R19
                    n.halt_evt = 1'b1; // R19
                end else if (accept) begin
                    n.st = S_FRAME;
                    n.mii_err = i_rx_er;
                    n.ovf = d_push && d_full;
                end
            end
            S_FRAME: begin
                n.mii_err = mii_seen;
                if (d_push && d_full) begin
                    n.ovf = 1'b1;
                end
                if (i_rx_eof) begin
                    n.st = S_IDLE;
                end
            end
            default: begin
                n.st = S_HALT;
            end
        endcase
        if (i_rd) begin
            case (i_addr)
                rsf_pkg::A_DATA: n.rdata = d_empty ? '0 : d_rdata;
                rsf_pkg::A_STAT: n.rdata = s_empty ? '0 : s_rdata; // R24
                rsf_pkg::A_RXCFG: n.rdata[rsf_pkg::CFG_FLUSH] = r.flush_req; // R3
                rsf_pkg::A_MACCR: begin
                    n.rdata[rsf_pkg::CR_RECEIVE_ENABLE_BIT] = r.receive_enable_bit;
                    n.rdata[rsf_pkg::CR_PASSBAD] = r.passbad;
                end
                rsf_pkg::A_INFO: begin
                    n.rdata[rsf_pkg::INFO_HALT] = (r.st == S_HALT);
                    n.rdata[rsf_pkg::INFO_ERR] = r.err;
                    n.rdata[rsf_pkg::INFO_SCNT +: 8] = 8'(s_used);
                    n.rdata[rsf_pkg::INFO_DCNT +: 16] = 16'(d_used);
                end
                default: n.rdata = '0;
            endcase
        end
        if (i_wr) begin
            case (i_addr)
                rsf_pkg::A_RXCFG: begin
                    if (i_wdata[rsf_pkg::CFG_FLUSH]) begin
                        n.flush_req = 1'b1;
                    end
                end
                rsf_pkg::A_MACCR: begin
                    n.receive_enable_bit = i_wdata[rsf_pkg::CR_RECEIVE_ENABLE_BIT];
                    n.passbad = i_wdata[rsf_pkg::CR_PASSBAD];
                end
                rsf_pkg::A_INFO: begin
                    if (i_wdata[rsf_pkg::INFO_ERR]) begin
                        n.err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // set after clear so a same-cycle event wins; receive_enable_bit is untouched
        if ((d_pop && d_empty) || (s_pop && s_empty) || (at_eof && s_full)) begin
            n.err = 1'b1; // R22
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            r <= '0;
            r.receive_enable_bit <= rsf_pkg::CR_RECEIVE_ENABLE_BIT_RST;
            r.passbad <= rsf_pkg::CR_PASSBAD_RST;
            r.flush_req <= rsf_pkg::CFG_FLUSH_RST;
        end else begin
            r <= n;
        end
    end

    assign o_rdata = r.rdata;
    assign o_receive_enable_bit = r.receive_enable_bit;
    assign o_rx_halted = (r.st == S_HALT);
    assign o_receiver_halted_event = r.halt_evt;
    assign o_receive_error_flag = r.err;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_reset);

    property p_flush_empty;
        r.flush_req |=> (d_empty && s_empty && !d_full && !s_full);
    endproperty
    a_flush_empty: assert property (p_flush_empty) // R1
        else $error("fifos not empty after flush");

    property p_flush_clear;
        r.flush_req && !i_wr |=> !r.flush_req;
    endproperty
    a_flush_clear: assert property (p_flush_clear) // R3
        else $error("flush request did not self clear");

    property p_reserved;
        s_push |-> (st_word[31] == 1'b0) && (st_word[14] == 1'b0)
            && (st_word[9:8] == 2'h0) && (st_word[0] == 1'b0);
    endproperty
    a_reserved: assert property (p_reserved) // R4
        else $error("reserved status bit set");

    property p_len;
        s_push |-> (st_word[29:16] == i_eof_len);
    endproperty
    a_len: assert property (p_len) // R6
        else $error("status length wrong");

    property p_summary;
        s_push |-> st_word[15] == (st_word[11] | st_word[7] | st_word[6] | st_word[1]);
    endproperty
    a_summary: assert property (p_summary) // R7
        else $error("error summary wrong");

    property p_runt_pass;
        s_push && st_word[11] |-> r.passbad;
    endproperty
    a_runt_pass: assert property (p_runt_pass) // R10
        else $error("runt delivered without pass bad");

    property p_dribble;
        s_push && st_word[6] |-> !st_word[2];
    endproperty
    a_dribble: assert property (p_dribble) // R17
        else $error("dribble with late collision");

    property p_halt_pulse;
        (r.st == S_IDLE) && !r.receive_enable_bit |=> o_receiver_halted_event ##1 !o_receiver_halted_event;
    endproperty
    a_halt_pulse: assert property (p_halt_pulse) // R19
        else $error("halted event not a single pulse");

    property p_err_keeps_rx;
        o_receive_error_flag && accept |=> (r.st == S_FRAME);
    endproperty
    a_err_keeps_rx: assert property (p_err_keeps_rx) // R21
        else $error("receiver stalled by error flag");

    property p_underrun;
        d_pop && d_empty |=> o_receive_error_flag;
    endproperty
    a_underrun: assert property (p_underrun) // R22
        else $error("underrun did not raise error");
endmodule

// ==== rsf_pkg.sv ====
/*
 rsf_pkg: register offsets, field positions, reset values and frame
 limits shared by the receive status/flush block and its testbench.
 Assumes byte addresses on the register port, one 32-bit word each.
*/
package rsf_pkg;
    // register byte offsets
    localparam logic [7:0] A_DATA = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_RXCFG = 8'h08;
    localparam logic [7:0] A_MACCR = 8'h0c;
    localparam logic [7:0] A_INFO = 8'h10;
    // field positions
    localparam int CFG_FLUSH = 0;
    localparam int CR_RECEIVE_ENABLE_BIT = 0;
    localparam int CR_PASSBAD = 16;
    localparam int INFO_HALT = 0;
    localparam int INFO_ERR = 1;
    localparam int INFO_SCNT = 8;
    localparam int INFO_DCNT = 16;
    // reset values
    localparam logic CR_RECEIVE_ENABLE_BIT_RST = 1'b0;
    localparam logic CR_PASSBAD_RST = 1'b0;
    localparam logic CFG_FLUSH_RST = 1'b0;
    // status word layout
    localparam int ST_FILT = 30;
    localparam int ST_LEN = 16;
    localparam int ST_ES = 15;
    localparam int ST_BCAST = 13;
    localparam int ST_LENERR = 12;
    localparam int ST_RUNT = 11;
    localparam int ST_MCAST = 10;
    localparam int ST_LONG = 7;
    localparam int ST_LATE = 6;
    localparam int ST_TYPE = 5;
    localparam int ST_WDOG = 4;
    localparam int ST_MIIERR = 3;
    localparam int ST_DRIB = 2;
    localparam int ST_CRC = 1;
    // frame limits in bytes, type field minimum and dribble bit counts
    localparam logic [13:0] RUNT_BYTES = 14'h0040;
    localparam logic [13:0] MAX_BYTES = 14'h05ee;
    localparam logic [13:0] HDR_BYTES = 14'h000e;
    localparam logic [13:0] WDOG_BYTES = 14'h0800;
    localparam logic [15:0] TYPE_MIN = 16'h05dc;
    localparam logic [2:0] DRIB_NIB = 3'h4;
    localparam logic [2:0] DRIB_10M = 3'h3;
endpackage

// ==== rsf_fifo.sv ====
/*
 rsf_fifo: flip-flop FIFO with flush and a commit point; the reader
 only sees committed words, so a frame in flight can be dropped.
 Assumes one clock, synchronous active-high reset.
*/
module rsf_fifo #(
    parameter int W = 32,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_reset,
    // control
    input wire logic i_flush,
    input wire logic i_commit,
    input wire logic i_drop,
    // write side
    input wire logic i_push,
    input wire logic [W-1:0] i_wdata,
    // read side
    input wire logic i_pop,
    output logic [W-1:0] o_rdata,
    output logic o_full,
    output logic o_empty,
    output logic [AW:0] o_used
);
    typedef struct packed {
        logic [2**AW-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] cp;
        logic [AW:0] rp;
    } rsf_fifo_s;

    rsf_fifo_s r;
    rsf_fifo_s n;

    assign o_full = (r.wp[AW] != r.rp[AW]) && (r.wp[AW-1:0] == r.rp[AW-1:0]);
    assign o_empty = (r.cp == r.rp);
    assign o_used = r.cp - r.rp;
    assign o_rdata = r.mem[r.rp[AW-1:0]];

    always_comb begin
        n = r;
        if (i_flush) begin
            // pointers back to reset state, content discarded
            n.wp = '0; // R1
            n.cp = '0; // R1
            n.rp = '0; // R1
        end else begin
            if (i_push && !o_full) begin
                n.mem[r.wp[AW-1:0]] = i_wdata;
                n.wp = r.wp + 1'b1;
            end
            if (i_drop) begin
                n.wp = r.cp;
            end else if (i_commit) begin
                n.cp = n.wp;
            end
            if (i_pop && !o_empty) begin
                n.rp = r.rp + 1'b1;
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end
endmodule

// ==== rsf_mac_model.sv ====
/*
 rsf_mac_model: behavioural mac receive source that plays frames into the
 receive block as start pulse, data words and an end pulse with facts.
 Assumes the caller starts send just after a rising edge of i_mclk.
*/
module rsf_mac_model (
    // clock
    input wire logic i_mclk,
    // frame link
    output logic o_sof,
    output logic o_wvalid,
    output logic [31:0] o_wdata,
    output logic o_er,
    output logic o_eof,
    output logic [13:0] o_len,
    output logic [15:0] o_typelen,
    output logic [5:0] o_flags,
    output logic [2:0] o_drib
);
    initial begin
        o_sof = 1'b0;
        o_wvalid = 1'b0;
        o_wdata = 32'h0;
        o_er = 1'b0;
        o_eof = 1'b0;
        o_len = 14'h0;
        o_typelen = 16'h0;
        o_flags = 6'h0;
        o_drib = 3'h0;
    end

    // words are {len, 2'b00, index}; facts only valid with the end pulse
    task automatic send(input logic [13:0] len, input logic [15:0] tl, input logic [5:0] fl,
                        input logic [2:0] drib, input int nw, input logic er_mid);
        for (int i = 0; i < nw; i++) begin
            @(posedge i_mclk);
            o_sof <= (i == 0);
            o_wvalid <= 1'b1;
            o_wdata <= {len, 2'b00, 16'(i)};
            o_er <= er_mid && (i == 1);
            o_eof <= (i == nw - 1);
            o_len <= len;
            o_typelen <= tl;
            o_flags <= fl;
            o_drib <= drib;
        end
        @(posedge i_mclk);
        o_sof <= 1'b0;
        o_wvalid <= 1'b0;
        o_eof <= 1'b0;
        o_er <= 1'b0;
        // released lines show inverted garbage, not the last value
        o_wdata <= ~o_wdata;
        o_len <= ~len;
        o_typelen <= ~tl;
        o_flags <= ~fl;
        o_drib <= ~drib;
    endtask
endmodule

// ==== tb_rsf_rx.sv ====
/*
 tb_rsf_rx: self-checking bench for rsf_rx: register port tasks, frames
 from the mac model, status packing, halt, flush and error flag.
 Assumes rsf_pkg offsets and the rsf_mac_model source.
*/
module tb_rsf_rx;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_mclk;
    logic i_reset;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    logic i_mii_mode;
    logic sof, wv, er, eof, en, halted, ev, err;
    logic [31:0] wd;
    logic [13:0] len;
    logic [15:0] tl;
    logic [5:0] fl;
    logic [2:0] drib;
    logic [31:0] d;
    int error_cnt = 0;
    int n_tests = 0;
    int npulse;
    // frame table: flags are {filt, bcast, mcast, len_err, late, crc}
    logic [13:0] lens [6] = '{14'h0064, 14'h0640, 14'h0834, 14'h0028, 14'h000a, 14'h0040};
    logic [15:0] tls [6] = '{16'h0800, 16'h0100, 16'h05dc, 16'h0800, 16'h0800, 16'h0600};
    logic [5:0] fls [6] = '{6'h11, 6'h0a, 6'h24, 6'h00, 6'h00, 6'h00};
    logic [2:0] dribs [6] = '{3'h0, 3'h4, 3'h0, 3'h0, 3'h0, 3'h3};
    logic ers [6] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
    logic miis [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};

    rsf_mac_model MAC (.i_mclk(i_mclk), .o_sof(sof), .o_wvalid(wv), .o_wdata(wd), .o_er(er),
        .o_eof(eof), .o_len(len), .o_typelen(tl), .o_flags(fl), .o_drib(drib));

    rsf_rx DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_rx_sof(sof), .i_rx_wvalid(wv),
        .i_rx_wdata(wd), .i_rx_er(er), .i_rx_eof(eof), .i_eof_len(len), .i_eof_typelen(tl),
        .i_eof_filt_fail(fl[5]), .i_eof_bcast(fl[4]), .i_eof_mcast(fl[3]),
        .i_eof_len_err(fl[2]), .i_eof_late_col(fl[1]), .i_eof_crc_bad(fl[0]),
        .i_eof_drib_bits(drib), .i_mii_mode(i_mii_mode), .o_receive_enable_bit(en),
        .o_rx_halted(halted), .o_receiver_halted_event(ev), .o_receive_error_flag(err));

    initial begin
        i_mclk = 1'b0;
        forever #5 i_mclk = ~i_mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_mclk);
        i_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        #1;
        v = o_rdata;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // status word worked out from the frame's facts
    function automatic logic [31:0] exp_st(input int k);
        logic [31:0] s;
        logic runt, lng, late, crc;
        s = 32'h0;
        runt = lens[k] < 14'h0040;
        lng = lens[k] > 14'h05ee;
        late = fls[k][1];
        crc = fls[k][0] | ers[k];
        s[30] = fls[k][5];
        s[29:16] = lens[k];
        s[15] = runt | lng | late | crc;
        s[13] = fls[k][4];
        s[12] = fls[k][2];
        s[11] = runt;
        s[10] = fls[k][3];
        s[7] = lng;
        s[6] = late;
        s[5] = (tls[k] > 16'h05dc) && (lens[k] >= 14'h000e);
        s[4] = lens[k] > 14'h0800;
        s[3] = ers[k];
        s[2] = (miis[k] ? dribs[k] == 3'h4 : dribs[k] >= 3'h3) && !late;
        s[1] = crc;
        return s;
    endfunction

    task automatic conclude();
        $display("mismatches=%0d comparisons=%0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #100us;
        error_cnt++;
        conclude();
    end

    initial begin
        i_reset = 1'b1;
        i_addr = 8'h0;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_mii_mode = 1'b1;
        repeat (3) @(posedge i_mclk);
        i_reset <= 1'b0;
        #1;
        rdchk(rsf_pkg::A_INFO, 32'h00000001);
        rdchk(rsf_pkg::A_MACCR, 32'h00000000);
        rdchk(rsf_pkg::A_STAT, 32'h00000000);
        rdchk(rsf_pkg::A_INFO, 32'h00000003);
        chk({31'h0, err}, 32'h1);
        wr(rsf_pkg::A_MACCR, 32'h00000001);
        repeat (2) @(posedge i_mclk);
        #1;
        chk({31'h0, halted}, 32'h0);
        chk({31'h0, en}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            if (k == 4)
                wr(rsf_pkg::A_MACCR, 32'h00010001);
            i_mii_mode <= miis[k];
            MAC.send(lens[k], tls[k], fls[k], dribs[k], 3, ers[k]);
            #1;
        end
        @(posedge i_mclk);
        #1;
        rdchk(rsf_pkg::A_INFO, 32'h000f0502);
        wr(rsf_pkg::A_INFO, 32'h00000002);
        rdchk(rsf_pkg::A_INFO, 32'h000f0500);
        chk({31'h0, err}, 32'h0);
        for (int k = 0; k < 6; k++) begin
            if (k != 3)
                rdchk(rsf_pkg::A_STAT, exp_st(k));
        end
        for (int i = 0; i < 3; i++)
            rdchk(rsf_pkg::A_DATA, {lens[0], 2'b00, 16'(i)});
        rdchk(rsf_pkg::A_INFO, 32'h000c0000);
        // leave one status word queued so the flush has to clear both fifos
        MAC.send(lens[0], tls[0], fls[0], dribs[0], 3, ers[0]);
        #1;
        rdchk(rsf_pkg::A_INFO, 32'h000f0100);
        wr(rsf_pkg::A_MACCR, 32'h00000000);
        npulse = 0;
        repeat (6) begin
            if (ev === 1'b1)
                npulse++;
            @(posedge i_mclk);
            #1;
        end
        chk(32'(npulse), 32'h1);
        chk({31'h0, halted}, 32'h1);
        chk({31'h0, en}, 32'h0);
        wr(rsf_pkg::A_RXCFG, 32'h00000001);
        d = 32'h1;
        for (int i = 0; i < 20 && d[0] !== 1'b0; i++)
            rd(rsf_pkg::A_RXCFG, d);
        chk(d, 32'h0);
        rdchk(rsf_pkg::A_INFO, 32'h00000001);
        rdchk(rsf_pkg::A_DATA, 32'h00000000);
        rdchk(rsf_pkg::A_INFO, 32'h00000003);
        i_reset <= 1'b1;
        @(posedge i_mclk);
        i_reset <= 1'b0;
        #1;
        rdchk(rsf_pkg::A_INFO, 32'h00000001);
        // seventeen frames into a sixteen-entry status fifo: last one dropped
        wr(rsf_pkg::A_MACCR, 32'h00000001);
        repeat (17) MAC.send(lens[0], tls[0], fls[0], dribs[0], 3, ers[0]);
        #1;
        chk({31'h0, err}, 32'h1);
        rdchk(rsf_pkg::A_INFO, 32'h00301002);
        conclude();
    end
endmodule
